/* File: verilog/cg_top.sv */
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "cg_consts.svh"

// Contract
// - Read starts with start then read address; device acknowledges a matching address.
// - After address ack the device sends byte count, then its configuration latches.
// - Configuration bytes go out in ascending order, byte 0 through byte 5.
// - Block writes only; bytes load ascending from byte 0 until a stop.
// - Command code and byte count bytes are acknowledged but their contents dropped.
// - Power-on sets every configuration byte to its default before any write.
// - During power-up dual-function pins are inputs sampled into a 5-bit strap latch.
// - After power-on reset those pins become clock outputs; latched straps are kept.
// - Power-down input is synchronised before it can start shutdown.
// - Power-down forces processor, PCI, SDRAM and strap-pin clocks low at next processor clock fall, then stops oscillator.
// - After power-down release, clocks resume within the power-up latency bound.
// - While powered down, both clock-stop inputs are ignored.
// - Reference and 48 MHz outputs stop low promptly; reference may take several cycles.
// - Processor stop is synchronised; only processor clocks stop low and restart full-width.
// - Processor clocks stop and restart within fewer than four processor clocks.
// - SDRAM feedback output follows its buffer input and ignores processor stop.
// - PCI stop is synchronised; gated PCI clocks stop low and restart full-width.
// - Gated PCI clocks stop one PCI clock after request, restart after three rises.
// - Write carries address, dummy command, dummy count, data; every byte acknowledged.
module cg_top
  import cg_pkg::*;
#(
  parameter int PWRUP_CYC = `CG_PWRUP_CYC,
  parameter int POR_CYC   = `CG_POR_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        power_down_n,
  input  wire logic        cpu_stop_n,
  input  wire logic        pci_stop_n,
  input  wire logic        cpu_clk_in,
  input  wire logic        pci_clk_in,
  input  wire logic        ref_clk_in,
  input  wire logic        usb48_clk_in,
  input  wire logic        sdram_buf_in,
  input  wire logic [4:0]  strap_pin_i,
  output logic      [4:0]  strap_pin_o,
  output logic      [4:0]  strap_pin_oe,
  output logic             processor_clk_out,
  output logic             gated_pci_clk_out,
  output logic             ref_clk_out,
  output logic             usb48_clk_out,
  output logic             sdram_fb_out,
  output logic             osc_en
);

  localparam logic [14:0] SYNC_INIT = 15'h7c00;

  cg_pins_s    raw;
  cg_pins_s    syn;
  cg_pins_s    prev_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        cpu_fall;
  logic        cpu_rise;
  logic        pci_rise;

  logic [2:0]  ctrl_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] rd_mux;
  logic [31:0] stat_w;
  logic        addr_hit;

  logic [15:0] por_cnt_r;
  logic        por_done_r;
  logic [4:0]  strap_r;
  logic [4:0]  strap_pin_o_r;
  logic [4:0]  strap_pin_oe_r;

  cg_pwr_e     pwr_st_r;
  logic [31:0] wake_cnt_r;
  logic        all_off_r;
  logic        osc_en_r;
  logic        ref_run_r;
  logic        u48_run_r;
  logic        pwrdn_req;
  logic        pwrdn_active;
  logic        cpu_run;
  logic        pci_run;
  logic        cpu_stop_req;
  logic        pci_stop_req;
  logic        proc_out_r;
  logic        pci_out_r;
  logic        ref_out_r;
  logic        u48_out_r;
  logic        sdram_out_r;

  cg_ser_e     ser_st_r;
  logic [7:0]  sh_r;
  logic [3:0]  cnt_r;
  logic [3:0]  idx_r;
  logic        rd_r;
  logic        adr_r;
  logic        sda_oe_r;
  logic        sda_o_r;
  logic [7:0]  cfg_r [`CG_NCFG];
  logic [7:0]  tx_b;
  logic        byte_done;

  // Pin sampling
  assign raw = '{scl: scl_i, sda: sda_i, pwrdn_n: power_down_n, cpu_stop_n: cpu_stop_n,
                 pci_stop_n: pci_stop_n, cpu: cpu_clk_in, pci: pci_clk_in, refc: ref_clk_in,
                 u48: usb48_clk_in, sdram: sdram_buf_in, strap: strap_pin_i};

  cg_sync3 #(
    .W    ($bits(cg_pins_s)),
    .INIT (SYNC_INIT)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .d        (raw),
    .q        (syn)
  );

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prev_r <= SYNC_INIT;
    end else begin
      prev_r <= syn;
    end
  end

  assign scl_rise  = syn.scl & ~prev_r.scl;
  assign scl_fall  = ~syn.scl & prev_r.scl;
  assign bus_start = syn.scl & prev_r.scl & prev_r.sda & ~syn.sda;
  assign bus_stop  = syn.scl & prev_r.scl & ~prev_r.sda & syn.sda;
  assign cpu_rise  = syn.cpu & ~prev_r.cpu;
  assign cpu_fall  = ~syn.cpu & prev_r.cpu;
  assign pci_rise  = syn.pci & ~prev_r.pci;

  // Power-on strap capture; pins stay inputs until the interval ends
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      por_cnt_r      <= 16'd0;
      por_done_r     <= 1'b0;
      strap_r        <= 5'h00;
      strap_pin_oe_r <= 5'h00;
    end else if (!por_done_r) begin
      if (por_cnt_r == 16'(POR_CYC)) begin
        por_done_r     <= 1'b1;
        strap_r        <= syn.strap;
        strap_pin_oe_r <= 5'h1f;
      end else begin
        por_cnt_r <= por_cnt_r + 16'd1;
      end
    end
  end

  // Power-down sequencing
  assign pwrdn_req    = ~syn.pwrdn_n | ctrl_r[`CG_CTRL_PWRDN];
  assign pwrdn_active = (pwr_st_r != P_RUN);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pwr_st_r   <= P_RUN;
      wake_cnt_r <= 32'd0;
      all_off_r  <= 1'b0;
      osc_en_r   <= 1'b1;
    end else begin
      case (pwr_st_r)
        P_RUN: begin
          if (pwrdn_req) begin
            pwr_st_r <= P_STOP;
          end
        end
        P_STOP: begin
          if (cpu_fall) begin
            all_off_r <= 1'b1;
            pwr_st_r  <= P_HOLD;
          end
        end
        P_HOLD: begin
          // Oscillator stops only once the reference and 48 MHz outputs are parked low
          if (!ref_run_r && !u48_run_r) begin
            osc_en_r <= 1'b0;
            pwr_st_r <= P_DOWN;
          end
        end
        P_DOWN: begin
          if (!pwrdn_req) begin
            osc_en_r   <= 1'b1;
            wake_cnt_r <= 32'd0;
            pwr_st_r   <= P_WAKE;
          end
        end
        P_WAKE: begin
          if (pwrdn_req) begin
            pwr_st_r <= P_HOLD;
          end else if (wake_cnt_r >= 32'(PWRUP_CYC - `CG_PWRUP_MARGIN)) begin
            all_off_r <= 1'b0;
            pwr_st_r  <= P_RUN;
          end else begin
            wake_cnt_r <= wake_cnt_r + 32'd1;
          end
        end
        default: begin
          pwr_st_r <= P_RUN;
        end
      endcase
    end
  end

  // Reference and 48 MHz stop on their own low phase, so the reference may lag
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ref_run_r <= 1'b1;
      u48_run_r <= 1'b1;
    end else if (pwrdn_active && pwr_st_r != P_WAKE) begin
      if (!syn.refc) begin
        ref_run_r <= 1'b0;
      end
      if (!syn.u48) begin
        u48_run_r <= 1'b0;
      end
    end else if (!pwrdn_active) begin
      if (!syn.refc) begin
        ref_run_r <= 1'b1;
      end
      if (!syn.u48) begin
        u48_run_r <= 1'b1;
      end
    end
  end

  // Clock-stop gating
  assign cpu_stop_req = (~syn.cpu_stop_n | ctrl_r[`CG_CTRL_CPUSTOP]) & ~pwrdn_active;
  assign pci_stop_req = (~syn.pci_stop_n | ctrl_r[`CG_CTRL_PCISTOP]) & ~pwrdn_active;

  cg_clk_gate #(
    .ON_RISES (3'(`CG_CPU_ON_RISES))
  ) u_cpu_gate (
    .core_clk (core_clk),
    .rstn     (rstn),
    .lv       (syn.cpu),
    .rise     (cpu_rise),
    .stop_req (cpu_stop_req),
    .run      (cpu_run)
  );

  cg_clk_gate #(
    .ON_RISES (3'(`CG_PCI_ON_RISES))
  ) u_pci_gate (
    .core_clk (core_clk),
    .rstn     (rstn),
    .lv       (syn.pci),
    .rise     (pci_rise),
    .stop_req (pci_stop_req),
    .run      (pci_run)
  );

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      proc_out_r    <= 1'b0;
      pci_out_r     <= 1'b0;
      ref_out_r     <= 1'b0;
      u48_out_r     <= 1'b0;
      sdram_out_r   <= 1'b0;
      strap_pin_o_r <= 5'h00;
    end else begin
      proc_out_r    <= syn.cpu & cpu_run & ~all_off_r;
      pci_out_r     <= syn.pci & pci_run & ~all_off_r;
      ref_out_r     <= syn.refc & ref_run_r;
      u48_out_r     <= syn.u48 & u48_run_r;
      sdram_out_r   <= syn.sdram & ~all_off_r;
      strap_pin_o_r <= {5{syn.pci & ~all_off_r & por_done_r}};
    end
  end

  // Serial configuration slave
  assign byte_done = scl_fall && (cnt_r == 4'd8);

  always_comb begin
    if (idx_r == 4'd0) begin
      tx_b = `CG_BYTE_CNT;
    end else if (idx_r <= 4'(`CG_NCFG)) begin
      tx_b = cfg_r[3'(idx_r - 4'd1)];
    end else begin
      tx_b = 8'hff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ser_st_r <= S_IDLE;
      sh_r     <= 8'h00;
      cnt_r    <= 4'd0;
      idx_r    <= 4'd0;
      rd_r     <= 1'b0;
      adr_r    <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      ser_st_r <= S_RX;
      cnt_r    <= 4'd0;
      adr_r    <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      ser_st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (ser_st_r)
        S_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        S_RX: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], syn.sda};
            cnt_r <= cnt_r + 4'd1;
          end else if (byte_done) begin
            cnt_r <= 4'd0;
            if (!adr_r) begin
              if (sh_r[7:1] == `CG_SLV_ADDR) begin
                sda_oe_r <= 1'b1;
                adr_r    <= 1'b1;
                rd_r     <= sh_r[0];
                idx_r    <= 4'd0;
                ser_st_r <= S_ACK;
              end else begin
                ser_st_r <= S_IDLE;
              end
            end else begin
              sda_oe_r <= 1'b1;
              ser_st_r <= S_ACK;
              if (idx_r != 4'hf) begin
                idx_r <= idx_r + 4'd1;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rd_r) begin
              sh_r     <= tx_b;
              sda_oe_r <= ~tx_b[7];
              cnt_r    <= 4'd1;
              ser_st_r <= S_TX;
            end else begin
              sda_oe_r <= 1'b0;
              ser_st_r <= S_RX;
            end
          end
        end
        S_TX: begin
          if (byte_done) begin
            sda_oe_r <= 1'b0;
            ser_st_r <= S_TXACK;
          end else if (scl_fall) begin
            sda_oe_r <= ~sh_r[6];
            sh_r     <= {sh_r[6:0], 1'b1};
            cnt_r    <= cnt_r + 4'd1;
          end
        end
        S_TXACK: begin
          // A host that withholds its acknowledge ends the read early
          if (scl_rise) begin
            if (!syn.sda) begin
              ser_st_r <= S_ACK;
              if (idx_r != 4'hf) begin
                idx_r <= idx_r + 4'd1;
              end
            end else begin
              ser_st_r <= S_IDLE;
            end
          end
        end
        default: begin
          ser_st_r <= S_IDLE;
        end
      endcase
    end
  end

  // Data bytes land ascending; command and count bytes are dropped
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < `CG_NCFG; i++) begin
        cfg_r[i] <= 8'(`CG_CFG_RST >> (8 * i));
      end
    end else if (ser_st_r == S_RX && byte_done && adr_r && !rd_r &&
                 idx_r >= 4'd2 && idx_r < 4'(`CG_NCFG + 2)) begin
      cfg_r[3'(idx_r - 4'd2)] <= sh_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sda_o_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets
  assign addr_hit = (paddr == `CG_OFF_CTRL) || (paddr == `CG_OFF_STAT) ||
                    (paddr == `CG_OFF_CFGLO) || (paddr == `CG_OFF_CFGHI);

  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[`CG_STAT_STRAP +: 5] = strap_r;
    stat_w[`CG_STAT_PWRDN]      = pwrdn_active;
    stat_w[`CG_STAT_CPUOFF]     = ~cpu_run;
    stat_w[`CG_STAT_PCIOFF]     = ~pci_run;
    stat_w[`CG_STAT_OSC]        = osc_en_r;
    stat_w[`CG_STAT_BUSY]       = (ser_st_r != S_IDLE);
  end

  always_comb begin
    case (paddr)
      `CG_OFF_CTRL:  rd_mux = {29'h0, ctrl_r};
      `CG_OFF_STAT:  rd_mux = stat_w;
      `CG_OFF_CFGLO: rd_mux = {cfg_r[3], cfg_r[2], cfg_r[1], cfg_r[0]};
      `CG_OFF_CFGHI: rd_mux = {16'h0000, cfg_r[5], cfg_r[4]};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~addr_hit;
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_r <= `CG_CTRL_RST;
    end else if (psel && penable && pready_r && pwrite && paddr == `CG_OFF_CTRL) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign sda_o             = sda_o_r;
  assign sda_oe            = sda_oe_r;
  assign strap_pin_o       = strap_pin_o_r;
  assign strap_pin_oe      = strap_pin_oe_r;
  assign processor_clk_out = proc_out_r;
  assign gated_pci_clk_out = pci_out_r;
  assign ref_clk_out       = ref_out_r;
  assign usb48_clk_out     = u48_out_r;
  assign sdram_fb_out      = sdram_out_r;
  assign osc_en            = osc_en_r;

endmodule

/* File: verilog/cg_consts.svh */
`ifndef CG_CONSTS_SVH
`define CG_CONSTS_SVH

// APB register byte offsets
`define CG_OFF_CTRL      8'h00
`define CG_OFF_STAT      8'h04
`define CG_OFF_CFGLO     8'h08
`define CG_OFF_CFGHI     8'h0c

// Control register fields
`define CG_CTRL_PWRDN    0
`define CG_CTRL_CPUSTOP  1
`define CG_CTRL_PCISTOP  2
`define CG_CTRL_RST      3'h0

// Status register fields
`define CG_STAT_STRAP    0
`define CG_STAT_PWRDN    8
`define CG_STAT_CPUOFF   9
`define CG_STAT_PCIOFF   10
`define CG_STAT_OSC      11
`define CG_STAT_BUSY     12

// Serial configuration port
`define CG_SLV_ADDR      7'h69
`define CG_BYTE_CNT      8'h06
`define CG_NCFG          6
`define CG_CFG_RST       48'h0000_0000_0000

// Timing
`define CG_CLK_NS        20
`define CG_POR_NS        1000
`define CG_POR_CYC       ((`CG_POR_NS + `CG_CLK_NS - 1) / `CG_CLK_NS)
`define CG_PWRUP_NS      4000000
`define CG_PWRUP_CYC     (`CG_PWRUP_NS / `CG_CLK_NS)
`define CG_PWRUP_MARGIN  4
`define CG_CPU_ON_RISES  1
`define CG_PCI_ON_RISES  3

`endif

/* File: verilog/cg_pkg.sv */
package cg_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACK,
    S_TX,
    S_TXACK
  } cg_ser_e;

  typedef enum logic [2:0] {
    P_RUN,
    P_STOP,
    P_HOLD,
    P_DOWN,
    P_WAKE
  } cg_pwr_e;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       pwrdn_n;
    logic       cpu_stop_n;
    logic       pci_stop_n;
    logic       cpu;
    logic       pci;
    logic       refc;
    logic       u48;
    logic       sdram;
    logic [4:0] strap;
  } cg_pins_s;

endpackage

/* File: verilog/cg_sync3.sv */
`timescale 1ns/1ps
module cg_sync3 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic q_r;
      // First stage feeds only the second; a change counts once stages two and three agree
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          s1_r <= INIT[i];
          s2_r <= INIT[i];
          s3_r <= INIT[i];
          q_r  <= INIT[i];
        end else begin
          s1_r <= d[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            q_r <= s3_r;
          end
        end
      end
      assign q[i] = q_r;
    end
  endgenerate

endmodule

/* File: verilog/cg_clk_gate.sv */
`timescale 1ns/1ps
module cg_clk_gate #(
  parameter logic [2:0] ON_RISES = 3'd1
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic lv,
  input  wire logic rise,
  input  wire logic stop_req,
  output logic      run
);

  logic       run_r;
  logic [2:0] cnt_r;

  // Gating changes only while the source is low, so no runt pulse escapes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      run_r <= 1'b1;
      cnt_r <= 3'd0;
    end else if (run_r) begin
      cnt_r <= 3'd0;
      if (stop_req && !lv) begin
        run_r <= 1'b0;
      end
    end else if (stop_req) begin
      cnt_r <= 3'd0;
    end else if (cnt_r >= ON_RISES && !lv) begin
      run_r <= 1'b1;
    end else if (rise && cnt_r < ON_RISES) begin
      cnt_r <= cnt_r + 3'd1;
    end
  end

  assign run = run_r;

endmodule

/* File: test/cg_top_properties.sv */
`timescale 1ns/1ps
`include "cg_consts.svh"
module cg_top_properties
  import cg_pkg::*;
#(
  parameter int PWRUP_CYC = 40,
  parameter int POR_CYC   = 8
) (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       power_down_n,
  input wire logic       cpu_stop_n,
  input wire logic       pci_stop_n,
  input wire logic       sdram_buf_in,
  input wire logic [4:0] strap_pin_o,
  input wire logic [4:0] strap_pin_oe,
  input wire logic       processor_clk_out,
  input wire logic       gated_pci_clk_out,
  input wire logic       ref_clk_out,
  input wire logic       usb48_clk_out,
  input wire logic       sdram_fb_out,
  input wire logic       osc_en
);
  // Run lengths saturate, so eight bits hold every bound used here
  logic [7:0] rel_r, pd_lo_r, pd_hi_r, cpu_lo_r;
  logic [7:0] pci_lo_r;
  logic       up;
  function automatic logic [7:0] sat(input logic c, input logic [7:0] x);
    return c ? x + {7'h00, x != 8'hff} : 8'h00;
  endfunction
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rel_r    <= 8'h00;
      pd_lo_r  <= 8'h00;
      pd_hi_r  <= 8'h00;
      cpu_lo_r <= 8'h00;
      pci_lo_r <= 8'h00;
    end else begin
      rel_r    <= sat(1'h1, rel_r);
      pd_lo_r  <= sat(!power_down_n, pd_lo_r);
      pd_hi_r  <= sat(power_down_n, pd_hi_r);
      cpu_lo_r <= sat(!cpu_stop_n, cpu_lo_r);
      pci_lo_r <= sat(!pci_stop_n, pci_lo_r);
    end
  end
  // Outputs count as running only once the wake delay is well past
  assign up = pd_hi_r > PWRUP_CYC + 16;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pd_rel;
    $rose(power_down_n);
  endsequence
  a_apb_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_apb_err: assert property (pready |-> pslverr == !(paddr inside {`CG_OFF_CTRL, `CG_OFF_STAT, `CG_OFF_CFGLO, `CG_OFF_CFGHI}))
    else $error("error flag wrong");
  a_strap_input: assert property (rel_r < POR_CYC |-> strap_pin_oe == 5'h00)
    else $error("strap pins driven early");
  a_strap_output: assert property (rel_r == POR_CYC + 3 |-> strap_pin_oe == 5'h1f)
    else $error("strap pins not driven");
  a_pd_all_low: assert property (pd_lo_r > 8'h18 |-> {processor_clk_out, gated_pci_clk_out, ref_clk_out, usb48_clk_out, strap_pin_o} == 9'h000)
    else $error("clock running in power down");
  a_osc_stop: assert property (pd_lo_r > 8'h28 |-> !osc_en)
    else $error("oscillator still on");
  a_osc_wake: assert property (s_pd_rel |-> ##[1:8] osc_en)
    else $error("oscillator not restarted");
  a_cpu_stop_low: assert property (cpu_lo_r > 8'h24 |-> !processor_clk_out)
    else $error("processor clock not stopped");
  a_pci_stop_low: assert property (pci_lo_r > 8'h1c |-> !gated_pci_clk_out)
    else $error("pci clock not stopped");
  a_sdram_free: assert property (up && cpu_lo_r > 8'h24 && $rose(sdram_buf_in) |-> ##[2:8] sdram_fb_out)
    else $error("sdram feedback gated");
endmodule

bind cg_top cg_top_properties #(.PWRUP_CYC(PWRUP_CYC), .POR_CYC(POR_CYC)) u_props (
  .core_clk, .rstn, .paddr, .psel, .penable, .pready, .pslverr, .power_down_n, .cpu_stop_n,
  .pci_stop_n, .sdram_buf_in, .strap_pin_o, .strap_pin_oe, .processor_clk_out,
  .gated_pci_clk_out, .ref_clk_out, .usb48_clk_out, .sdram_fb_out, .osc_en
);

/* File: test/cg_host_model.sv */
`timescale 1ns/1ps
module cg_host_model
  import cg_pkg::*;
#(
  parameter int Q = 125
) (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  // Quarter bit of Q cycles: 500 cycles a bit is 100 kbit/s, never faster
  initial begin
    scl  = 1'h1;
    pull = 1'h0;
  end
  task automatic qw();
    repeat (Q) @(posedge core_clk);
  endtask
  task automatic start();
    pull <= 1'h1;
    qw();
    scl <= 1'h0;
    qw();
  endtask
  task automatic stop();
    pull <= 1'h1;
    qw();
    scl <= 1'h1;
    qw();
    pull <= 1'h0;
    qw();
  endtask
  // Data changes only while SCL is low, so a start or stop is never faked
  task automatic bit_x(input logic b, output logic s);
    pull <= !b;
    qw();
    scl <= 1'h1;
    qw();
    s = sda;
    qw();
    scl <= 1'h0;
    qw();
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(last, ack);
  endtask
endmodule

/* File: test/cg_top_tb.sv */
`timescale 1ns/1ps
`include "cg_consts.svh"
module cg_top_tb
  import cg_pkg::*;
;
  localparam int PWRUP = 40;
  localparam int POR   = 8;
  logic        core_clk = 1'h0;
  logic        rstn = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, sda_o, sda_oe, scl, pull, osc_en;
  logic        power_down_n = 1'h1, cpu_stop_n = 1'h1, pci_stop_n = 1'h1;
  logic [4:0]  src, strap_res = 5'h15, strap_pin_o, strap_pin_oe;
  logic        processor_clk_out, gated_pci_clk_out, ref_clk_out, usb48_clk_out, sdram_fb_out;
  logic [5:0]  outs;
  logic [7:0]  wseq [6] = '{8'hd2, 8'ha5, 8'h03, 8'h11, 8'h22, 8'h33};
  logic [7:0]  rexp [7] = '{8'h06, 8'h11, 8'h22, 8'h33, 8'h00, 8'h00, 8'h00};
  int          fail_count = 0, n_compared = 0;
  wire logic [4:0] strap_w = (strap_pin_oe & strap_pin_o) | (~strap_pin_oe & strap_res);
  wire logic       sda_w = !pull && !(sda_oe && !sda_o);
  assign outs = {strap_pin_o[0], sdram_fb_out, usb48_clk_out, ref_clk_out, gated_pci_clk_out, processor_clk_out};
  always #10 core_clk = ~core_clk;
  // Source clocks run free at 160 ns, offset so no edge meets a core edge
  initial begin
    src = 5'h0a;
    #7;
    forever #80 src = ~src;
  end
  cg_top #(.PWRUP_CYC(PWRUP), .POR_CYC(POR)) uut (
    .core_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe, .power_down_n, .cpu_stop_n, .pci_stop_n,
    .cpu_clk_in(src[0]), .pci_clk_in(src[1]), .ref_clk_in(src[2]), .usb48_clk_in(src[3]),
    .sdram_buf_in(src[4]), .strap_pin_i(strap_w), .strap_pin_o, .strap_pin_oe, .processor_clk_out,
    .gated_pci_clk_out, .ref_clk_out, .usb48_clk_out, .sdram_fb_out, .osc_en
  );
  cg_host_model host (.core_clk, .sda(sda_w), .scl, .pull);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    // No wait-state limit here: only the watchdog may end a hung access
    while (pready !== 1'h1) begin
      @(posedge core_clk);
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wait_hi(input int i, input int lim, output int n);
    n = 0;
    while (outs[i] !== 1'h1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic hi_width(input int i, output int w);
    w = 0;
    while (outs[i] === 1'h1 && w < 20) begin
      @(posedge core_clk);
      w++;
    end
  endtask
  task automatic low_for(input logic [5:0] m, input int n, input string what);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge core_clk);
      bad += ((outs & m) !== 6'h00);
    end
    chk(what, 32'h0, bad);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    logic [31:0] q;
    logic [7:0]  b;
    logic        e, ack;
    int          n, w;
    repeat (4) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (POR + 8) @(posedge core_clk);
    chk("strap oe", 32'h1f, strap_pin_oe);
    strap_res <= 5'h0a;
    apb(1'h1, `CG_OFF_STAT, 32'hffff_ffff, q, e);
    apb(1'h0, `CG_OFF_STAT, 32'h0, q, e);
    chk("strap latch", 32'h15, q[4:0]);
    wait_hi(5, 40, n);
    chk("strap pin clock", 32'h1, outs[5]);
    apb(1'h1, `CG_OFF_CTRL, 32'h2, q, e);
    apb(1'h0, `CG_OFF_CTRL, 32'h0, q, e);
    chk("ctrl", 32'h2, q);
    apb(1'h1, `CG_OFF_CTRL, 32'h0, q, e);
    apb(1'h0, 8'h10, 32'h0, q, e);
    chk("unmapped err", 32'h1, e);
    apb(1'h0, `CG_OFF_CFGLO, 32'h0, q, e);
    chk("cfg reset", 32'h0, q);
    host.start();
    foreach (wseq[k]) begin
      host.xfer(wseq[k], 1'h1, b, ack);
      chk("write ack", 32'h0, ack);
    end
    host.stop();
    apb(1'h0, `CG_OFF_CFGLO, 32'h0, q, e);
    chk("cfg low", 32'h0033_2211, q);
    apb(1'h0, `CG_OFF_CFGHI, 32'h0, q, e);
    chk("cfg high", 32'h0, q);
    host.start();
    host.xfer(8'hd3, 1'h1, b, ack);
    chk("read addr ack", 32'h0, ack);
    foreach (rexp[k]) begin
      host.xfer(8'hff, 1'h0, b, ack);
      chk("read byte", rexp[k], b);
    end
    host.stop();
    host.start();
    host.xfer(8'ha4, 1'h1, b, ack);
    chk("foreign addr nack", 32'h1, ack);
    host.stop();
    // One stop period each, so the minimum high spacing always holds
    cpu_stop_n <= 1'h0;
    repeat (36) @(posedge core_clk);
    low_for(6'h01, 40, "cpu stopped");
    cpu_stop_n <= 1'h1;
    wait_hi(0, 60, n);
    chk("cpu on latency", 32'h1, n < 36);
    hi_width(0, w);
    chk("cpu first pulse", 32'h4, w);
    pci_stop_n <= 1'h0;
    repeat (28) @(posedge core_clk);
    low_for(6'h02, 40, "pci stopped");
    pci_stop_n <= 1'h1;
    wait_hi(1, 80, n);
    chk("pci on latency", 32'h1, n >= 20 && n < 48);
    hi_width(1, w);
    chk("pci first pulse", 32'h4, w);
    power_down_n <= 1'h0;
    repeat (30) @(posedge core_clk);
    cpu_stop_n <= 1'h0;
    low_for(6'h2f, 40, "powered down");
    apb(1'h0, `CG_OFF_STAT, 32'h0, q, e);
    chk("pd status", 32'h1, {q[11], q[8]});
    cpu_stop_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    power_down_n <= 1'h1;
    wait_hi(0, PWRUP + 60, n);
    chk("wake latency", 32'h1, n >= PWRUP - 8 && n < PWRUP + 24);
    chk("osc on", 32'h1, osc_en);
    report_and_stop();
  end
endmodule
